// ==== ucb_pkg.sv ====
// Package for the UART checksum, collision and baud generator support block
package ucb_pkg;
    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int          UCB_DIV_W      = 16;
    localparam int          UCB_SUM_W      = 8;
    localparam logic [7:0]  UCB_SYNC_CHAR  = 8'h55;
    localparam logic [2:0]  UCB_AB_EDGES   = 3'h5;
    localparam logic [3:0]  UCB_HS_PRE     = 4'h3;  // Fosc/4 base: 4 clocks per tick
    localparam logic [3:0]  UCB_NS_PRE     = 4'hF;  // Fosc/16 base: 16 clocks per tick
    localparam logic [2:0]  UCB_AB_SLOW    = 3'h7;  // ABD clock is base/8
    localparam logic [15:0] UCB_DIV_RESET  = 16'h0000;
    localparam logic [3:0]  UCB_MODE_LIN   = 4'h8;
    localparam logic [3:0]  UCB_MODE_DALI  = 4'hA;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ucb_byte_s;

    typedef struct packed {
        logic [3:0] mode;
        logic       speed_select;
        logic       receiver_enable;
        logic       transmitter_enable;
        logic       checksum_enable;
        logic       wakeup_enable;
    } ucb_cfg_s;

    typedef enum logic [1:0] {AB_IDLE, AB_WAIT_START, AB_MEASURE, AB_FINISH} ucb_ab_e;
endpackage : ucb_pkg

// ==== ucb_accum.sv ====
// Byte accumulator with carry folded into the running sum
`timescale 1ns/10ps
`default_nettype none
module ucb_accum
    import ucb_pkg::*;
(
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    input  wire logic                 CE,
    input  wire logic                 CLEAR,
    input  wire logic                 ENABLE,
    input  wire ucb_byte_s            BYTE_IN,
    output logic [UCB_SUM_W-1:0]      SUM
);
    logic [UCB_SUM_W:0] wide_d;

    // Clear wins only when no byte lands in the same cycle
    assign wide_d = {1'b0, SUM} + {1'b0, BYTE_IN.data};

    always_ff @(posedge CLK) begin
        if (RESET) begin
            SUM <= 8'h00;
        end else if (CE) begin
            if (ENABLE && BYTE_IN.valid) begin
                SUM <= wide_d[7:0] + {7'h00, wide_d[8]};
            end else if (CLEAR) begin
                SUM <= 8'h00;
            end
        end
    end

    a_sum_holds: assert property (@(posedge CLK) disable iff (RESET)
        (CE && !ENABLE && !CLEAR) |=> $stable(SUM))
        else $error("checksum changed while disabled");
endmodule : ucb_accum
`default_nettype wire

// ==== ucb_top.sv ====
// UART support: checksums, collision detection, activity, baud generator, auto-baud
// Function
// - Enabled adders sum each byte with carry
// - Checksum error flag inactive outside LIN
// - Collision check whenever receiver and transmitter enabled
// - Flag collision when received word differs
// - DALI: missing mid-bit transition flags collision
// - Line activity resets hardware-limit timer
// - Free-running 16-bit timer, divisor sets period
// - Speed select picks 4 or 16 clocks
// - Divisor write resets baud timer immediately
// - Auto-baud enable ignored in LIN mode
// - First falling edge starts counting, receiver idle
// - Fifth fall loads divisor, sets done
// - Idle status low first fall, high fifth rise
// - Internal counter; visible divisor held until done
// - Auto-baud counter runs at base/8
// - With wake-up, measure byte after break
// - Overflow sets flag, keeps searching, divisor kept
`timescale 1ns/10ps
`default_nettype none
module ucb_top
    import ucb_pkg::*;
(
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    input  wire logic                 CE,
    input  wire ucb_cfg_s             CFG,
    input  wire ucb_byte_s            TX_BYTE,
    input  wire ucb_byte_s            RX_BYTE,
    input  wire logic                 TX_CHK_CLEAR,
    input  wire logic                 RX_CHK_CLEAR,
    input  wire logic                 LIN_CHK_BAD,
    input  wire logic                 DALI_MIDBIT_MISSING,
    input  wire logic                 TX_LINE,
    input  wire logic                 RX_LINE,
    input  wire logic                 ACT_SEL_RX,
    input  wire logic                 DIV_WRITE,
    input  wire logic [15:0]          DIV_WDATA,
    input  wire logic                 AB_START,
    input  wire logic                 AB_CANCEL,
    input  wire logic                 BREAK_DONE,
    input  wire logic                 COLL_CLEAR,
    input  wire logic                 CHKERR_CLEAR,
    input  wire logic                 AB_DONE_CLEAR,
    input  wire logic                 AB_OVF_CLEAR,
    output logic [7:0]                TX_CHECKSUM_SUM,
    output logic [7:0]                RX_CHECKSUM_SUM,
    output logic                      CHECKSUM_ERROR_FLAG,
    output logic                      COLLISION_FLAG,
    output logic                      HLT_RESET,
    output logic [15:0]               BAUD_DIVISOR,
    output logic                      BAUD_TICK,
    output logic                      AUTOBAUD_ENABLE,
    output logic                      AUTOBAUD_DONE_FLAG,
    output logic                      AUTOBAUD_OVERFLOW_FLAG,
    output logic                      RECEIVER_IDLE_STATUS,
    output logic                      RX_HOLD_IDLE
);
    // ------------------------------------------------------------------
    // Local state
    // ------------------------------------------------------------------
    logic        is_lin;
    logic        is_dali;
    logic        coll_active;
    logic [7:0]  tx_word_q;
    logic        tx_word_v_q;
    logic        tx_line_q;
    logic        rx_line_q;
    logic        rx_fall;
    logic        rx_rise;
    logic [3:0]  pre_q;
    logic        base_tick;
    logic [15:0] brg_q;
    logic [2:0]  ab_pre_q;
    logic [16:0] ab_cnt_q;
    logic [2:0]  falls_q;
    logic        ab_wait_break_q;
    ucb_ab_e     ab_state_q;

    function automatic logic mode_is(input logic [3:0] m, input logic [3:0] ref_m);
        mode_is = (m == ref_m);
    endfunction : mode_is

    assign is_lin  = mode_is(CFG.mode, UCB_MODE_LIN);
    assign is_dali = mode_is(CFG.mode, UCB_MODE_DALI);

    // ------------------------------------------------------------------
    // Checksum adders
    // ------------------------------------------------------------------
    ucb_accum u_tx_sum (
        .CLK    (CLK),
        .RESET  (RESET),
        .CE     (CE),
        .CLEAR  (TX_CHK_CLEAR),
        .ENABLE (CFG.checksum_enable),
        .BYTE_IN(TX_BYTE),
        .SUM    (TX_CHECKSUM_SUM)
    );

    ucb_accum u_rx_sum (
        .CLK    (CLK),
        .RESET  (RESET),
        .CE     (CE),
        .CLEAR  (RX_CHK_CLEAR),
        .ENABLE (CFG.checksum_enable),
        .BYTE_IN(RX_BYTE),
        .SUM    (RX_CHECKSUM_SUM)
    );

    // Only LIN framing reports checksum errors; set beats clear
    always_ff @(posedge CLK) begin
        if (RESET) begin
            CHECKSUM_ERROR_FLAG <= 1'b0;
        end else if (CE) begin
            if (!is_lin) begin
                CHECKSUM_ERROR_FLAG <= 1'b0;
            end else if (LIN_CHK_BAD) begin
                CHECKSUM_ERROR_FLAG <= 1'b1;
            end else if (CHKERR_CLEAR) begin
                CHECKSUM_ERROR_FLAG <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Collision detection
    // ------------------------------------------------------------------
    assign coll_active = CFG.receiver_enable && CFG.transmitter_enable;

    // Transmitted word is held until its echo arrives
    always_ff @(posedge CLK) begin
        if (RESET) begin
            tx_word_q   <= 8'h00;
            tx_word_v_q <= 1'b0;
        end else if (CE) begin
            if (TX_BYTE.valid) begin
                tx_word_q   <= TX_BYTE.data;
                tx_word_v_q <= 1'b1;
            end else if (RX_BYTE.valid) begin
                tx_word_v_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            COLLISION_FLAG <= 1'b0;
        end else if (CE) begin
            if (coll_active && tx_word_v_q && RX_BYTE.valid
                && RX_BYTE.data != tx_word_q) begin
                COLLISION_FLAG <= 1'b1;
            end else if (coll_active && is_dali && tx_word_v_q && DALI_MIDBIT_MISSING) begin
                COLLISION_FLAG <= 1'b1;
            end else if (COLL_CLEAR) begin
                COLLISION_FLAG <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Line activity for the hardware-limit timer
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            tx_line_q <= 1'b1;
            rx_line_q <= 1'b1;
        end else if (CE) begin
            tx_line_q <= TX_LINE;
            rx_line_q <= RX_LINE;
        end
    end

    assign rx_fall = rx_line_q && !RX_LINE;
    assign rx_rise = !rx_line_q && RX_LINE;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            HLT_RESET <= 1'b0;
        end else if (CE) begin
            HLT_RESET <= ACT_SEL_RX ? (rx_line_q != RX_LINE)
                                    : (tx_line_q != TX_LINE);
        end
    end

    // ------------------------------------------------------------------
    // Baud rate generator
    // ------------------------------------------------------------------
    assign base_tick = (pre_q == (CFG.speed_select ? UCB_HS_PRE : UCB_NS_PRE));

    always_ff @(posedge CLK) begin
        if (RESET) begin
            pre_q <= 4'h0;
        end else if (CE) begin
            if (DIV_WRITE || base_tick) begin
                pre_q <= 4'h0;
            end else begin
                pre_q <= pre_q + 4'h1;
            end
        end
    end

    // Free-running timer; a divisor write restarts it so the new rate starts now
    always_ff @(posedge CLK) begin
        if (RESET) begin
            brg_q     <= 16'h0000;
            BAUD_TICK <= 1'b0;
        end else if (CE) begin
            BAUD_TICK <= 1'b0;
            if (DIV_WRITE) begin
                brg_q <= 16'h0000;
            end else if (base_tick) begin
                if (brg_q >= BAUD_DIVISOR) begin
                    brg_q     <= 16'h0000;
                    BAUD_TICK <= 1'b1;
                end else begin
                    brg_q <= brg_q + 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Auto-baud
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ab_state_q      <= AB_IDLE;
            AUTOBAUD_ENABLE <= 1'b0;
            ab_wait_break_q <= 1'b0;
            ab_cnt_q        <= 17'h00000;
            ab_pre_q        <= 3'h0;
            falls_q         <= 3'h0;
            BAUD_DIVISOR    <= UCB_DIV_RESET;
        end else if (CE) begin
            if (DIV_WRITE) begin
                BAUD_DIVISOR <= DIV_WDATA;
            end
            case (ab_state_q)
                AB_IDLE: begin
                    if (AB_START && !is_lin) begin
                        AUTOBAUD_ENABLE <= 1'b1;
                        ab_wait_break_q <= CFG.wakeup_enable;
                        ab_state_q      <= AB_WAIT_START;
                    end
                end
                AB_WAIT_START: begin
                    if (AB_CANCEL) begin
                        AUTOBAUD_ENABLE <= 1'b0;
                        ab_state_q      <= AB_IDLE;
                    end else if (ab_wait_break_q) begin
                        ab_wait_break_q <= !BREAK_DONE;
                    end else if (rx_fall) begin
                        ab_cnt_q   <= 17'h00000;
                        ab_pre_q   <= 3'h0;
                        falls_q    <= 3'h1;
                        ab_state_q <= AB_MEASURE;
                    end
                end
                AB_MEASURE: begin
                    if (AB_CANCEL) begin
                        AUTOBAUD_ENABLE <= 1'b0;
                        ab_state_q      <= AB_IDLE;
                    end else begin
                        if (base_tick) begin
                            ab_pre_q <= ab_pre_q + 3'h1;
                            if (ab_pre_q == UCB_AB_SLOW && !ab_cnt_q[16]) begin
                                ab_cnt_q <= ab_cnt_q + 17'h00001;
                            end
                        end
                        if (rx_fall) begin
                            falls_q <= falls_q + 3'h1;
                            if (falls_q == UCB_AB_EDGES - 3'h1) begin
                                if (!ab_cnt_q[16]) begin
                                    BAUD_DIVISOR <= ab_cnt_q[15:0];
                                end
                                AUTOBAUD_ENABLE <= 1'b0;
                                ab_state_q      <= AB_FINISH;
                            end
                        end
                    end
                end
                AB_FINISH: begin
                    if (rx_rise) begin
                        ab_state_q <= AB_IDLE;
                    end
                end
                default: ab_state_q <= AB_IDLE;
            endcase
        end
    end

    assign RX_HOLD_IDLE = (ab_state_q == AB_WAIT_START) || (ab_state_q == AB_MEASURE);
    assign RECEIVER_IDLE_STATUS = (ab_state_q != AB_MEASURE) && (ab_state_q != AB_FINISH);

    // Set wins over software clear
    always_ff @(posedge CLK) begin
        if (RESET) begin
            AUTOBAUD_DONE_FLAG <= 1'b0;
        end else if (CE) begin
            if (ab_state_q == AB_MEASURE && rx_fall && falls_q == UCB_AB_EDGES - 3'h1
                && !AB_CANCEL) begin
                AUTOBAUD_DONE_FLAG <= 1'b1;
            end else if (AB_DONE_CLEAR) begin
                AUTOBAUD_DONE_FLAG <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            AUTOBAUD_OVERFLOW_FLAG <= 1'b0;
        end else if (CE) begin
            if (ab_state_q == AB_MEASURE && ab_cnt_q[16]) begin
                AUTOBAUD_OVERFLOW_FLAG <= 1'b1;
            end else if (AB_OVF_CLEAR) begin
                AUTOBAUD_OVERFLOW_FLAG <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_chkerr_lin: assert property (@(posedge CLK) disable iff (RESET)
        (CE && !is_lin) |=> !CHECKSUM_ERROR_FLAG)
        else $error("checksum error flag outside LIN");
    a_coll_needs_en: assert property (@(posedge CLK) disable iff (RESET)
        $rose(COLLISION_FLAG) |-> $past(coll_active))
        else $error("collision flagged with enables off");
    a_coll_mismatch: assert property (@(posedge CLK) disable iff (RESET)
        (CE && coll_active && tx_word_v_q && RX_BYTE.valid && RX_BYTE.data != tx_word_q)
        |=> COLLISION_FLAG)
        else $error("mismatch not flagged");
    a_hlt_activity: assert property (@(posedge CLK) disable iff (RESET)
        (CE && ACT_SEL_RX && rx_fall) |=> HLT_RESET)
        else $error("rx activity missed");
    a_div_restart: assert property (@(posedge CLK) disable iff (RESET)
        (CE && DIV_WRITE) |=> (brg_q == 16'h0000 && pre_q == 4'h0))
        else $error("divisor write did not restart timer");
    a_lin_no_ab: assert property (@(posedge CLK) disable iff (RESET)
        (CE && is_lin && ab_state_q == AB_IDLE) |=> !AUTOBAUD_ENABLE)
        else $error("auto-baud started in LIN");
    a_ab_done: assert property (@(posedge CLK) disable iff (RESET)
        $rose(AUTOBAUD_DONE_FLAG) |-> (!AUTOBAUD_ENABLE && ab_state_q == AB_FINISH))
        else $error("done flag without completion");
    a_div_held: assert property (@(posedge CLK) disable iff (RESET)
        (ab_state_q == AB_MEASURE && !DIV_WRITE && !(rx_fall && falls_q == 3'h4))
        |=> $stable(BAUD_DIVISOR))
        else $error("divisor changed mid measurement");
    a_idle_low: assert property (@(posedge CLK) disable iff (RESET)
        (CE && ab_state_q == AB_WAIT_START && !ab_wait_break_q && !AB_CANCEL && rx_fall)
        |=> !RECEIVER_IDLE_STATUS)
        else $error("idle not low after first fall");

    c_ab_ok:   cover property (@(posedge CLK) $rose(AUTOBAUD_DONE_FLAG));
    c_ab_ovf:  cover property (@(posedge CLK) $rose(AUTOBAUD_OVERFLOW_FLAG));
    c_coll:    cover property (@(posedge CLK) $rose(COLLISION_FLAG));
    c_tick:    cover property (@(posedge CLK) BAUD_TICK);
endmodule : ucb_top
`default_nettype wire

// ==== ucb_remote_uart.sv ====
// Remote UART model that sends one 8N1 character onto the receive line
`timescale 1ns/10ps
`default_nettype none
module ucb_remote_uart (
    input  wire logic        CLK,
    input  wire logic        GO,
    input  wire logic [15:0] BIT_CYC,
    input  wire logic [7:0]  DATA,
    output var  logic        LINE,
    output var  logic        BUSY
);
    logic [9:0] bits;

    // Line rests at the mark level between frames, as a pulled-up line would
    initial begin
        LINE = 1'b1;
        BUSY = 1'b0;
        forever begin
            @(posedge CLK);
            if (GO === 1'b1) begin
                bits = {1'b1, DATA, 1'b0};
                @(negedge CLK);
                BUSY = 1'b1;
                // Bits change only on falling edges, away from the sampling edge
                for (int i = 0; i < 10; i++) begin
                    LINE = bits[i];
                    repeat (BIT_CYC) @(negedge CLK);
                end
                BUSY = 1'b0;
            end
        end
    end
endmodule : ucb_remote_uart
`default_nettype wire

// ==== uart_checksum_collision_baud_gen_tb.sv ====
// Testbench for the UART checksum, collision and baud generator block
`timescale 1ns/10ps
`default_nettype none
module uart_checksum_collision_baud_gen_tb;
    import ucb_pkg::*;
    logic        clk, reset, tx_line, act_sel_rx, div_write, ab_start, ab_cancel, ce;
    logic        tx_chk_clear, rx_chk_clear, lin_chk_bad, dali_miss, break_done;
    logic        coll_clear, chkerr_clear, ab_done_clear, rx_line, go, busy;
    logic [15:0] div_wdata, bit_cyc, div_seen, baud_div;
    ucb_cfg_s    cfg;
    ucb_byte_s   txb, rxb;
    logic [7:0]  tx_sum, rx_sum;
    logic        chk_err, coll, hlt_rst, tick, ab_en, ab_done, ab_ovf, rx_idle, rx_hold;
    int          n_mismatch, checks_done, n;

    ucb_top ucb_top_inst (.CLK(clk), .RESET(reset), .CE(ce), .CFG(cfg), .TX_BYTE(txb),
        .RX_BYTE(rxb), .TX_CHK_CLEAR(tx_chk_clear), .RX_CHK_CLEAR(rx_chk_clear),
        .LIN_CHK_BAD(lin_chk_bad), .DALI_MIDBIT_MISSING(dali_miss), .TX_LINE(tx_line),
        .RX_LINE(rx_line), .ACT_SEL_RX(act_sel_rx), .DIV_WRITE(div_write),
        .DIV_WDATA(div_wdata), .AB_START(ab_start), .AB_CANCEL(ab_cancel),
        .BREAK_DONE(break_done), .COLL_CLEAR(coll_clear), .CHKERR_CLEAR(chkerr_clear),
        .AB_DONE_CLEAR(ab_done_clear), .AB_OVF_CLEAR(1'b0), .TX_CHECKSUM_SUM(tx_sum),
        .RX_CHECKSUM_SUM(rx_sum), .CHECKSUM_ERROR_FLAG(chk_err), .COLLISION_FLAG(coll),
        .HLT_RESET(hlt_rst), .BAUD_DIVISOR(baud_div), .BAUD_TICK(tick),
        .AUTOBAUD_ENABLE(ab_en), .AUTOBAUD_DONE_FLAG(ab_done),
        .AUTOBAUD_OVERFLOW_FLAG(ab_ovf), .RECEIVER_IDLE_STATUS(rx_idle),
        .RX_HOLD_IDLE(rx_hold));

    ucb_remote_uart ucb_remote_uart_inst (.CLK(clk), .GO(go), .BIT_CYC(bit_cyc),
        .DATA(8'h55), .LINE(rx_line), .BUSY(busy));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse

    task automatic put(input logic to_tx, input logic [7:0] d);
        if (to_tx) txb = {1'b1, d};
        else rxb = {1'b1, d};
        cyc(1);
        txb.valid = 1'b0;
        rxb.valid = 1'b0;
        // Gap cycle so a following call never re-raises valid in this step
        cyc(1);
    endtask : put

    // Counts clocks between two ticks; a stuck generator ends the wait
    task automatic period(output int p);
        p = 0;
        for (int i = 0; i < 3000 && tick !== 1'b1; i++) cyc(1);
        do begin
            cyc(1);
            p++;
        end while (tick !== 1'b1 && p < 3000);
    endtask : period

    task automatic frame(input logic mid);
        pulse(go);
        cyc(bit_cyc / 2);
        if (mid) begin
            chk("rx idle", rx_idle, 1'b0);
            chk("held divisor", baud_div, div_seen);
        end
        for (int i = 0; i < 20000 && busy; i++) cyc(1);
        cyc(2);
    endtask : frame

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole sequence needs about 10k cycles; allow well over twice that
    initial begin
        #500000;
        n_mismatch++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {reset, tx_line, act_sel_rx, div_write, ab_start, ab_cancel} = 6'b110000;
        {tx_chk_clear, rx_chk_clear, lin_chk_bad, dali_miss, break_done} = '0;
        {coll_clear, chkerr_clear, ab_done_clear, go} = '0;
        div_wdata = '0;
        ce = 1'b1;
        bit_cyc = 16'h0080;
        cfg = '0;
        txb = '0;
        rxb = '0;
        n_mismatch = 0;
        checks_done = 0;
        cyc(20);
        reset = 1'b0;
        chk("reset sums", {tx_sum, rx_sum}, 16'h0000);
        chk("reset divisor", baud_div, UCB_DIV_RESET);
        chk("reset flags", {chk_err, coll, ab_en, ab_done, ab_ovf, rx_hold}, 16'h0000);
        chk("reset idle", rx_idle, 1'b1);
        // Checksums: carry folds back, inverted sum closes the transaction
        pulse(tx_chk_clear);
        pulse(rx_chk_clear);
        cfg.checksum_enable = 1'b1;
        put(1'b1, 8'h01);
        put(1'b1, 8'hFF);
        chk("tx sum", tx_sum, 16'h0001);
        put(1'b0, 8'h12);
        put(1'b0, 8'h34);
        put(1'b0, ~8'h46);
        chk("rx sum", rx_sum, 16'h00FF);
        chk("rx verdict", 8'(rx_sum + 8'h01), 16'h0000);
        ce = 1'b0;
        put(1'b0, 8'h05);
        chk("rx sum frozen", rx_sum, 16'h00FF);
        ce = 1'b1;
        cfg.checksum_enable = 1'b0;
        put(1'b0, 8'h05);
        chk("rx sum off", rx_sum, 16'h00FF);
        pulse(lin_chk_bad);
        chk("chk err async", chk_err, 1'b0);
        cfg.mode = UCB_MODE_LIN;
        pulse(lin_chk_bad);
        chk("chk err lin", chk_err, 1'b1);
        pulse(chkerr_clear);
        chk("chk err clear", chk_err, 1'b0);
        pulse(ab_start);
        chk("ab enable lin", ab_en, 1'b0);
        cfg.mode = 4'h0;
        // Collision detection
        cfg.receiver_enable = 1'b1;
        put(1'b1, 8'h5A);
        put(1'b0, 8'h5B);
        chk("coll one enable", coll, 1'b0);
        cfg.transmitter_enable = 1'b1;
        put(1'b1, 8'h5A);
        put(1'b0, 8'h5A);
        chk("coll match", coll, 1'b0);
        put(1'b1, 8'h5A);
        put(1'b0, 8'h5B);
        chk("coll differ", coll, 1'b1);
        pulse(coll_clear);
        chk("coll clear", coll, 1'b0);
        cfg.mode = UCB_MODE_DALI;
        put(1'b1, 8'h33);
        pulse(dali_miss);
        chk("coll dali", coll, 1'b1);
        put(1'b0, 8'h33);
        pulse(coll_clear);
        cfg.mode = 4'h0;
        // Line activity restarts the limit timer only on the chosen line
        for (int sel = 0; sel < 2; sel++) begin
            act_sel_rx = sel[0];
            n = 0;
            tx_line = ~tx_line;
            repeat (4) begin
                cyc(1);
                n += int'(hlt_rst === 1'b1);
            end
            chk("hlt resets", 16'(n), 16'(1 - sel));
        end
        // ------------------------------------------------------------------
        // Baud generator and auto-baud
        // ------------------------------------------------------------------
        for (int s = 0; s < 2; s++) begin
            cfg.speed_select = s[0];
            div_wdata = 16'h0003;
            pulse(div_write);
            chk("divisor", baud_div, 16'h0003);
            period(n);
            chk("tick period", 16'(n), s ? 16'h0010 : 16'h0040);
        end
        cfg.speed_select = 1'b1;
        div_wdata = 16'h00FF;
        pulse(div_write);
        cyc(20);
        div_wdata = 16'h0001;
        pulse(div_write);
        n = 0;
        while (tick !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        chk("restart tick", 16'(n), 16'h0008);
        for (int s = 0; s < 2; s++) begin
            chk("idle before clock", rx_idle, 1'b1);
            cfg.speed_select = s[0];
            bit_cyc = s ? 16'h0080 : 16'h0200;
            div_seen = baud_div;
            pulse(ab_start);
            chk("ab enable", ab_en, 1'b1);
            chk("rx hold", rx_hold, 1'b1);
            frame(1'b1);
            chk("ab done", {ab_done, ab_en, rx_idle}, 16'h0005);
            chk("ab divisor", 16'(baud_div >= 31 && baud_div <= 33), 16'h0001);
            chk("ab overflow", ab_ovf, 1'b0);
            cyc(10);
            chk("ab done kept", ab_done, 1'b1);
            pulse(ab_done_clear);
            chk("ab done clear", ab_done, 1'b0);
        end
        cfg.speed_select = 1'b1;
        bit_cyc = 16'h0080;
        cfg.wakeup_enable = 1'b1;
        pulse(ab_start);
        frame(1'b0);
        chk("ab before break", {ab_done, ab_en}, 16'h0001);
        pulse(break_done);
        frame(1'b0);
        chk("ab after break", {ab_done, ab_en}, 16'h0002);
        cfg.wakeup_enable = 1'b0;
        pulse(ab_done_clear);
        pulse(ab_start);
        pulse(ab_cancel);
        chk("ab cancel", {ab_done, ab_en}, 16'h0000);
        conclude();
    end
endmodule : uart_checksum_collision_baud_gen_tb
`default_nettype wire
